/* File: core/lpm_ctrl_pkg.sv */
// package for the power-mode controller: mode codes, grant struct and timing counts
// assumes a 10 MHz system clock; wake figures are typical values turned into cycles
package lpm_ctrl_pkg;

    typedef enum logic [3:0] {
        active_mode,
        active_nvm_off_mode,
        cpu_off_mode_a,
        cpu_off_mode_b,
        standby_mode_a,
        standby_mode_b,
        all_off_mode,
        rtc_only_mode,
        shutdown_svs_mode,
        shutdown_mode
    } power_mode_type;

    typedef struct packed {
        logic main_clock_on;
        logic subsystem_clock_on;
        logic aux_clock_on;
        logic nvm_on;
        logic hf_allowed;
        logic lf_allowed;
        logic unclocked_allowed;
        logic rtc_only_run;
        logic periph_reset;
        logic core_supply_on;
        logic cpu_reset;
    } grant_type;

    typedef struct packed {
        logic any_event;
        logic lf_periph;
        logic io_pin;
        logic comparator;
        logic rtc;
        logic dma;
    } wake_type;

    localparam int unsigned clk_hz            = 10_000_000;
    localparam int unsigned clk_period_ns     = 1_000_000_000 / clk_hz;
    localparam int unsigned wake_std_ns       = 6000;
    localparam int unsigned wake_deep_ns      = 7000;
    localparam int unsigned wake_rtc_ns       = 250000;
    localparam int unsigned wake_shutdown_ns  = 1000000;
    localparam int unsigned nvm_power_up_ns   = 6000;
    // all times round down to whole cycles; no floor of one cycle is applied
    localparam int unsigned wake_std_cyc      = wake_std_ns / clk_period_ns;
    localparam int unsigned wake_deep_cyc     = wake_deep_ns / clk_period_ns;
    localparam int unsigned wake_rtc_cyc      = wake_rtc_ns / clk_period_ns;
    localparam int unsigned wake_shutdown_cyc = wake_shutdown_ns / clk_period_ns;
    localparam int unsigned nvm_power_up_cyc  = nvm_power_up_ns / clk_period_ns;
    localparam int unsigned count_width       = 14;
    localparam int unsigned sys_limit_high_hz = 16_000_000;
    localparam int unsigned sys_limit_low_hz  = 50_000;

endpackage : lpm_ctrl_pkg

/* File: core/lpm_delay_counter.sv */
// down counter that times one wake-up or power-up phase
// assumes load and the count value arrive together in one cycle
`timescale 1ns/1ps
module lpm_delay_counter #(
    parameter int unsigned width = 14
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             load,
    input  wire logic [width-1:0] load_value,
    output logic                  done
);
    logic [width-1:0] count;
    logic [width-1:0] next_count;

    always_comb
    begin
        next_count = count;
        if (load)
        begin
            next_count = load_value;
        end
        else if (count != '0)
        begin
            next_count = count - width'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

    // done on the last counted cycle, so a phase lasts load_value cycles;
    // not gated by load, so a reload on done cannot loop back into done
    assign done = (count <= width'(1));
endmodule : lpm_delay_counter

/* File: core/lpm_grant_table.sv */
// combinational map from a power mode to the clocks, memory and peripheral states it allows
// assumes the caller registers the result before it leaves the block
`timescale 1ns/1ps
module lpm_grant_table (
    input  lpm_ctrl_pkg::power_mode_type mode,
    input  wire logic                    subsystem_clock_off_bit,
    output lpm_ctrl_pkg::grant_type      grant,
    output lpm_ctrl_pkg::wake_type       wake_mask
);
    import lpm_ctrl_pkg::*;

    always_comb
    begin
        grant     = '0;
        wake_mask = '0;
        grant.core_supply_on = 1'b1;
        case (mode)
            active_mode, active_nvm_off_mode:
            begin
                grant.main_clock_on      = 1'b1;
                grant.nvm_on             = (mode == active_mode);
                grant.subsystem_clock_on = !subsystem_clock_off_bit;
                grant.aux_clock_on       = 1'b1;
                grant.hf_allowed         = 1'b1;
                grant.lf_allowed         = 1'b1;
                grant.unclocked_allowed  = 1'b1;
            end
            cpu_off_mode_a, cpu_off_mode_b:
            begin
                // light sleep keeps the memory in standby in cpu_off_mode_a only; cpu_off_mode_b switches it off
                grant.nvm_on             = (mode == cpu_off_mode_a);
                grant.subsystem_clock_on = !subsystem_clock_off_bit;
                grant.aux_clock_on       = 1'b1;
                grant.hf_allowed         = 1'b1;
                grant.lf_allowed         = 1'b1;
                grant.unclocked_allowed  = 1'b1;
                wake_mask.any_event      = 1'b1;
            end
            standby_mode_a, standby_mode_b:
            begin
                grant.aux_clock_on      = 1'b1;
                grant.lf_allowed        = 1'b1;
                grant.unclocked_allowed = 1'b1;
                wake_mask.lf_periph     = 1'b1;
                wake_mask.io_pin        = 1'b1;
                wake_mask.comparator    = 1'b1;
            end
            all_off_mode:
            begin
                grant.unclocked_allowed = 1'b1;
                wake_mask.io_pin        = 1'b1;
                wake_mask.comparator    = 1'b1;
            end
            rtc_only_mode:
            begin
                grant.rtc_only_run   = 1'b1;
                grant.periph_reset   = 1'b1;
                grant.core_supply_on = 1'b0;
                grant.cpu_reset      = 1'b1;
                wake_mask.rtc        = 1'b1;
                wake_mask.io_pin     = 1'b1;
            end
            default:
            begin
                grant.periph_reset   = 1'b1;
                grant.core_supply_on = 1'b0;
                grant.cpu_reset      = 1'b1;
                wake_mask.io_pin     = 1'b1;
            end
        endcase
        // dma can run a transfer that stays away from the memory in the cpu-off, standby and all-off modes only
        wake_mask.dma = (mode inside {cpu_off_mode_a, cpu_off_mode_b, standby_mode_a, standby_mode_b, all_off_mode});
    end
endmodule : lpm_grant_table

/* File: core/low_power_mode_control.sv */
// power-mode controller: takes mode requests from the core and grants clocks, memory and peripherals
// assumes core requests are synchronous one-cycle pulses on clk_sys; nrst is the brownout reset
`timescale 1ns/1ps
module low_power_mode_control
    import lpm_ctrl_pkg::*;
#(
    parameter int unsigned wake_rtc_cycles      = wake_rtc_cyc,
    parameter int unsigned wake_shutdown_cycles = wake_shutdown_cyc
) (
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    input  wire logic                    mode_req,
    input  lpm_ctrl_pkg::power_mode_type mode_req_value,
    input  wire logic                    subsystem_clock_off_bit,
    input  wire logic                    irq_return,
    input  lpm_ctrl_pkg::wake_type       wake_event,
    output lpm_ctrl_pkg::power_mode_type mode,
    output lpm_ctrl_pkg::grant_type      grant,
    output logic                         cpu_run,
    output logic                         dma_run,
    output logic                         wake_busy,
    output logic                         sys_limit_low
);
    import lpm_ctrl_pkg::*;

    typedef enum logic [2:0] {
        st_run,
        st_sleep,
        st_wake,
        st_nvm_up,
        st_isr,
        st_dma
    } state_type;

    // ==================================================
    // mode table
    // ==================================================
    grant_type table_grant;
    wake_type  wake_mask;
    power_mode_type table_mode;

    state_type      state;
    state_type      next_state;
    power_mode_type sleep_mode;
    power_mode_type next_sleep_mode;
    power_mode_type next_mode;
    logic           nvm_off;
    logic           next_nvm_off;
    logic           next_cpu_run;
    logic           next_dma_run;
    logic           next_wake_busy;
    logic           load;
    logic [count_width-1:0] load_value;
    logic           timer_done;
    wake_type       hit;
    logic           wake_any;

    // a dma trigger alone never wakes the core
    localparam wake_type dma_only = '{dma: 1'b1, default: 1'b0};

    lpm_grant_table u_table (
        .mode                    (table_mode),
        .subsystem_clock_off_bit (subsystem_clock_off_bit),
        .grant                   (table_grant),
        .wake_mask               ()
    );

    // wake mask follows the registered mode so the sleep decision has no loop through next_mode
    lpm_grant_table u_wake_table (
        .mode                    (mode),
        .subsystem_clock_off_bit (subsystem_clock_off_bit),
        .grant                   (),
        .wake_mask               (wake_mask)
    );

    lpm_delay_counter #(
        .width (count_width)
    ) u_timer (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .load       (load),
        .load_value (load_value),
        .done       (timer_done)
    );

    function automatic logic retained(input power_mode_type m);
        retained = m inside {cpu_off_mode_a, cpu_off_mode_b, standby_mode_a, standby_mode_b, all_off_mode};
    endfunction : retained

    function automatic logic [count_width-1:0] wake_time(input power_mode_type m);
        case (m)
            cpu_off_mode_a:                   wake_time = count_width'(1);
            cpu_off_mode_b, standby_mode_a:   wake_time = count_width'(wake_std_cyc);
            standby_mode_b, all_off_mode:     wake_time = count_width'(wake_deep_cyc);
            rtc_only_mode, shutdown_svs_mode: wake_time = count_width'(wake_rtc_cycles);
            default:                          wake_time = count_width'(wake_shutdown_cycles);
        endcase
    endfunction : wake_time

    assign hit      = wake_event & wake_mask;
    assign wake_any = wake_mask.any_event ? ((wake_event & ~dma_only) != '0) : ((hit & ~dma_only) != '0);

    // ==================================================
    // sequencer
    // ==================================================
    always_comb
    begin
        next_state      = state;
        next_sleep_mode = sleep_mode;
        next_mode       = mode;
        next_nvm_off    = nvm_off;
        load            = 1'b0;
        load_value      = '0;
        table_mode      = next_mode;
        case (state)
            st_run, st_isr:
            begin
                if (state == st_isr && irq_return)
                begin
                    next_state = st_sleep;
                end
                else if (mode_req)
                begin
                    next_mode  = mode_req_value;
                    next_state = st_run;
                    if (mode_req_value == active_nvm_off_mode)
                    begin
                        next_nvm_off = 1'b1;
                    end
                    else if (mode_req_value == active_mode)
                    begin
                        next_nvm_off = 1'b0;
                    end
                    else
                    begin
                        next_sleep_mode = mode_req_value;
                        next_state      = st_sleep;
                        if (mode_req_value == cpu_off_mode_b || !retained(mode_req_value))
                        begin
                            next_nvm_off = 1'b1;
                        end
                    end
                end
            end
            st_sleep:
            begin
                if (wake_any)
                begin
                    load       = 1'b1;
                    load_value = wake_time(sleep_mode);
                    next_state = st_wake;
                end
                else if (hit.dma)
                begin
                    next_state = st_dma;
                end
            end
            st_dma:
            begin
                if (!wake_event.dma)
                begin
                    next_state = st_sleep;
                end
            end
            st_wake:
            begin
                if (timer_done)
                begin
                    if (nvm_off)
                    begin
                        load       = 1'b1;
                        load_value = count_width'(nvm_power_up_cyc);
                        next_state = st_nvm_up;
                    end
                    else
                    begin
                        next_state = retained(sleep_mode) ? st_isr : st_run;
                    end
                end
            end
            st_nvm_up:
            begin
                if (timer_done)
                begin
                    next_nvm_off = 1'b0;
                    next_state   = retained(sleep_mode) ? st_isr : st_run;
                end
            end
            default:
            begin
                next_state = st_run;
            end
        endcase
        // a fresh start after a supply-off mode keeps nothing
        if (state == st_nvm_up && timer_done && !retained(sleep_mode))
        begin
            next_mode       = active_mode;
            next_sleep_mode = active_mode;
        end
        else if (state == st_wake && timer_done && !nvm_off && !retained(sleep_mode))
        begin
            next_mode       = active_mode;
            next_sleep_mode = active_mode;
        end
        else if (next_state == st_isr || next_state == st_dma)
        begin
            // memory state after this edge decides the active variant
            next_mode = next_nvm_off ? active_nvm_off_mode : active_mode;
        end
        else if (next_state == st_sleep)
        begin
            next_mode = next_sleep_mode;
        end
        table_mode     = next_mode;
        next_cpu_run   = (next_state == st_run) || (next_state == st_isr);
        next_dma_run   = (next_state == st_dma);
        next_wake_busy = (next_state == st_wake) || (next_state == st_nvm_up);
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state         <= st_run;
            mode          <= active_mode;
            sleep_mode    <= active_mode;
            nvm_off       <= 1'b0;
            grant         <= '0;
            cpu_run       <= 1'b0;
            dma_run       <= 1'b0;
            wake_busy     <= 1'b0;
            sys_limit_low <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            mode          <= next_mode;
            sleep_mode    <= next_sleep_mode;
            nvm_off       <= next_nvm_off;
            grant         <= table_grant;
            grant.nvm_on  <= table_grant.nvm_on && !next_nvm_off;
            cpu_run       <= next_cpu_run;
            dma_run       <= next_dma_run;
            wake_busy     <= next_wake_busy;
            sys_limit_low <= next_mode inside {standby_mode_a, standby_mode_b, rtc_only_mode};
        end
    end

    // ==================================================
    // checks
    // ==================================================
    a_hf_in_standby: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode inside {standby_mode_a, standby_mode_b, all_off_mode}) |-> !grant.hf_allowed)
        else $error("high-frequency peripherals allowed in standby or off");
    a_lf_in_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode == all_off_mode) |-> !grant.lf_allowed && !grant.aux_clock_on)
        else $error("low-frequency peripherals allowed in off mode");
    a_unclocked_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode inside {rtc_only_mode, shutdown_mode, shutdown_svs_mode}) |-> grant.periph_reset && !grant.unclocked_allowed)
        else $error("unclocked peripherals not reset in deepest modes");
    a_supply_cut: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode inside {rtc_only_mode, shutdown_mode}) |-> !grant.core_supply_on && grant.cpu_reset)
        else $error("core supply left on in deep mode");
    a_subsys_deep: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode inside {standby_mode_a, standby_mode_b, all_off_mode}) |-> !grant.subsystem_clock_on)
        else $error("subsystem clock on in deep mode");
    a_main_clock: assert property (@(posedge clk_sys) disable iff (!nrst)
        grant.main_clock_on |-> (mode inside {active_mode, active_nvm_off_mode}))
        else $error("main clock on outside active modes");
    a_nvm_off_run: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode == active_nvm_off_mode && state == st_run) |-> cpu_run && !grant.nvm_on)
        else $error("memory on in memory-off active mode");
    a_dma_no_delay: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == st_sleep && !wake_any && hit.dma) |=> dma_run && !wake_busy)
        else $error("dma wake was delayed");
    a_nvm_slow_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == st_wake && timer_done && nvm_off) |=> state == st_nvm_up && !cpu_run)
        else $error("memory power-up skipped on wake");
    a_isr_return: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == st_isr && irq_return) |=> state == st_sleep && mode == sleep_mode)
        else $error("handler return did not re-enter sleep");
endmodule : low_power_mode_control

/* File: verification/cpu_core_model.sv */
// model of the processor core: issues mode requests and interrupt returns
// assumes the controller samples both pulses on the rising edge of clk_sys
`timescale 1ns/1ps
module cpu_core_model
    import lpm_ctrl_pkg::*;
(
    input  wire logic                    clk_sys,
    output logic                         mode_req,
    output lpm_ctrl_pkg::power_mode_type mode_req_value,
    output logic                         irq_return
);
    initial
    begin
        mode_req       = 1'b0;
        mode_req_value = active_mode;
        irq_return     = 1'b0;
    end

    // value is scrambled once the pulse is over so a stale value cannot match
    task automatic request(input power_mode_type m);
        @(posedge clk_sys);
        mode_req       <= 1'b1;
        mode_req_value <= m;
        @(posedge clk_sys);
        mode_req       <= 1'b0;
        mode_req_value <= power_mode_type'(~m);
    endtask : request

    task automatic ret();
        @(posedge clk_sys);
        irq_return <= 1'b1;
        @(posedge clk_sys);
        irq_return <= 1'b0;
    endtask : ret
endmodule : cpu_core_model

/* File: verification/tb.sv */
// self-checking bench for the power-mode controller
// assumes the core model drives requests; rtc and shutdown wake counts shortened to 5
`timescale 1ns/1ps
module tb;
    import lpm_ctrl_pkg::*;
    logic           clk_sys;
    logic           nrst;
    logic           mode_req;
    power_mode_type mode_req_value;
    logic           subsystem_clock_off_bit;
    logic           irq_return;
    wake_type       wake_event;
    power_mode_type mode;
    grant_type      grant;
    logic           cpu_run;
    logic           dma_run;
    logic           wake_busy;
    logic           sys_limit_low;
    int             n_fail = 0;
    int             n_compared = 0;

    low_power_mode_control #(.wake_rtc_cycles(5), .wake_shutdown_cycles(5)) low_power_mode_control_inst (
        .clk_sys(clk_sys), .nrst(nrst), .mode_req(mode_req), .mode_req_value(mode_req_value),
        .subsystem_clock_off_bit(subsystem_clock_off_bit), .irq_return(irq_return),
        .wake_event(wake_event), .mode(mode), .grant(grant), .cpu_run(cpu_run),
        .dma_run(dma_run), .wake_busy(wake_busy), .sys_limit_low(sys_limit_low));
    cpu_core_model cpu_core_model_inst (
        .clk_sys(clk_sys), .mode_req(mode_req), .mode_req_value(mode_req_value),
        .irq_return(irq_return));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ====================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    function automatic grant_type exp_grant(input power_mode_type m, input logic off);
        exp_grant.main_clock_on      = m <= active_nvm_off_mode;
        exp_grant.subsystem_clock_on = m <= cpu_off_mode_b && !off;
        exp_grant.aux_clock_on       = m <= standby_mode_b;
        exp_grant.nvm_on             = m == active_mode || m == cpu_off_mode_a;
        exp_grant.hf_allowed         = m <= cpu_off_mode_b;
        exp_grant.lf_allowed         = m <= standby_mode_b;
        exp_grant.unclocked_allowed  = m <= all_off_mode;
        exp_grant.rtc_only_run       = m == rtc_only_mode;
        exp_grant.periph_reset       = m >= rtc_only_mode;
        exp_grant.core_supply_on     = m < rtc_only_mode;
        exp_grant.cpu_reset          = m >= rtc_only_mode;
    endfunction : exp_grant

    // n counts cycles of wake timing before the core runs again
    task automatic wake(input wake_type w, output int n);
        int k;
        n = 0;
        @(posedge clk_sys);
        wake_event <= w;
        @(posedge clk_sys);
        wake_event <= '0;
        for (k = 0; k < 12000; k++)
        begin
            @(posedge clk_sys);
            #1;
            if (cpu_run === 1'b1)
                break;
            if (wake_busy === 1'b1)
                n++;
        end
        if (k == 12000)
        begin
            n_fail++;
            $display("CHECK FAILED wake expected cpu_run 1 seen 0");
            test_done();
        end
    endtask : wake

    // ====================================================
    // scenarios
    task automatic test_reset();
        tick(2);
        check("mode", 32'(mode), 32'(active_mode));
        check("grant", 32'(grant), 32'(exp_grant(active_mode, 1'b0)));
        check("cpu_run", 32'(cpu_run), 32'h1);
        $display("test reset done");
    endtask : test_reset

    task automatic test_modes();
        power_mode_type m;
        wake_type       io;
        wake_type       bad;
        int             n;
        io = '0;
        io.io_pin = 1'b1;
        for (int i = 2; i <= 9; i++)
        begin
            m = power_mode_type'(i);
            bad = '0;
            if (m == standby_mode_a || m == standby_mode_b || m >= shutdown_svs_mode)
                bad.rtc = 1'b1;
            else if (m == all_off_mode || m == rtc_only_mode)
                bad.lf_periph = 1'b1;
            cpu_core_model_inst.request(m);
            tick(2);
            check("mode", 32'(mode), 32'(m));
            check("cpu_run", 32'(cpu_run), 32'h0);
            check("grant", 32'(grant), 32'(exp_grant(m, 1'b0)));
            if (m <= standby_mode_b)
                check("sys_limit_low", 32'(sys_limit_low), 32'(m >= standby_mode_a));
            if (bad !== '0)
            begin
                @(posedge clk_sys);
                wake_event <= bad;
                @(posedge clk_sys);
                wake_event <= '0;
                tick(3);
                check("ignored wake busy", 32'(wake_busy), 32'h0);
                check("ignored wake mode", 32'(mode), 32'(m));
            end
            wake(io, n);
            check("woken mode", 32'(mode), 32'(active_mode));
            if (m <= all_off_mode)
            begin
                cpu_core_model_inst.ret();
                tick(2);
                check("return mode", 32'(mode), 32'(m));
                check("return cpu_run", 32'(cpu_run), 32'h0);
                wake(io, n);
                cpu_core_model_inst.request(active_mode);
                tick(2);
            end
        end
        $display("test modes done");
    endtask : test_modes

    task automatic test_wake_time();
        wake_type w;
        wake_type d;
        int       n_on;
        int       n_off;
        w = '0;
        w.io_pin = 1'b1;
        d = '0;
        d.dma = 1'b1;
        cpu_core_model_inst.request(cpu_off_mode_a);
        wake(w, n_on);
        cpu_core_model_inst.request(active_nvm_off_mode);
        tick(2);
        check("nvm_on", 32'(grant.nvm_on), 32'h0);
        check("cpu_run", 32'(cpu_run), 32'h1);
        cpu_core_model_inst.request(cpu_off_mode_a);
        wake(w, n_off);
        check("extra wake cycles", 32'(n_off - n_on), 32'(nvm_power_up_cyc));
        cpu_core_model_inst.request(standby_mode_a);
        @(posedge clk_sys);
        wake_event <= d;
        tick(3);
        check("dma_run", 32'(dma_run), 32'h1);
        check("dma wake_busy", 32'(wake_busy), 32'h0);
        @(posedge clk_sys);
        wake_event <= '0;
        tick(3);
        check("after dma mode", 32'(mode), 32'(standby_mode_a));
        wake(w, n_on);
        cpu_core_model_inst.request(active_mode);
        tick(2);
        $display("test wake time done");
    endtask : test_wake_time

    task automatic test_ssoff();
        wake_type w;
        int       n;
        w = '0;
        w.io_pin = 1'b1;
        @(posedge clk_sys);
        subsystem_clock_off_bit <= 1'b1;
        tick(2);
        check("grant off bit", 32'(grant), 32'(exp_grant(active_mode, 1'b1)));
        cpu_core_model_inst.request(cpu_off_mode_b);
        tick(2);
        check("grant off bit", 32'(grant), 32'(exp_grant(cpu_off_mode_b, 1'b1)));
        wake(w, n);
        cpu_core_model_inst.request(active_mode);
        @(posedge clk_sys);
        subsystem_clock_off_bit <= 1'b0;
        tick(2);
        $display("test subsystem clock done");
    endtask : test_ssoff

    initial
    begin
        nrst = 1'b0;
        subsystem_clock_off_bit = 1'b0;
        wake_event = '0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        test_reset();
        test_modes();
        test_wake_time();
        test_ssoff();
        test_done();
    end
endmodule : tb
